// ==== design/oas_pkg.sv ====
package oas_pkg;

  // ==========================================================
  // operand modes, instruction classes, address spaces, stack commands and stack states
  typedef enum logic [2:0] {
    reg_mode,
    work_reg_mode,
    pointer_held_mode,
    indexed_mode,
    absolute_target_mode,
    vector_table_jump_mode,
    pc_displacement_mode,
    literal_operand_mode
  } oas_mode_e;

  typedef enum logic [2:0] {
    register_move_instr,
    program_memory_load,
    external_data_load,
    jump_instr,
    call_instr,
    other_instr
  } oas_instr_e;

  typedef enum logic [2:0] {
    space_none,
    space_regfile,
    space_pmem,
    space_xdata,
    space_pc
  } oas_space_e;

  typedef enum logic [1:0] {
    stk_call,
    stk_return,
    stk_intr,
    interrupt_return
  } oas_stk_cmd_e;

  typedef enum logic [2:0] {
    st_idle,
    st_push_lo,
    st_push_hi,
    st_push_fl,
    st_pop_fl,
    st_pop_hi,
    st_pop_lo
  } oas_stk_state_e;

  // ==========================================================
  // register map and address ranges
  localparam logic [7:0] STACK_PTR_ADDR = 8'hd9;
  localparam logic [7:0] STACK_PTR_RESET = 8'hc0;
  localparam logic [7:0] COMMON_BASE = 8'hc0;
  localparam logic [7:0] COMMON_TOP = 8'hcf;
  localparam logic [7:0] SYSTEM_BASE = 8'hc0;
  localparam logic [7:0] VECTOR_PAGE = 8'h00;
  localparam int SLICE_LSB = 3;

  // ==========================================================
  // carriers
  typedef struct packed {
    oas_mode_e mode;
    oas_instr_e instr;
    logic is_pair;
    logic long_off;
    logic [3:0] wsel;
    logic [15:0] field;
  } oas_req_s;

  typedef struct packed {
    oas_space_e space;
    logic [15:0] ea;
    logic [15:0] operand;
    logic invalid;
    logic page_bypass;
    logic pc_load;
    logic vec_fetch;
  } oas_res_s;

endpackage

// ==== design/oas_operand_address_and_stack.sv ====
`timescale 1ns/1ps

// What this block does
// (RL1) common sixteen bytes bypass register page
// (RL2) pairs start even, high byte first
// (RL3) direct address of common area invalid
// (RL4) call pushes pc, return pops it
// (RL5) interrupt pushes pc and flags, restores both
// (RL6) pre-decrement push, post-increment pop
// (RL7) stack pointer byte mapped at d9h
// (RL8) stack pointer wraps modulo 256
// (RL9) register mode operand is register contents
// (RL10) pointer picks 8-byte slice, field picks register
// (RL11) pointer-held mode: register holds operand address
// (RL12) pointer-held mode cannot reach c0h-ffh
// (RL13) indexed mode cannot reach c0h-ffh
// (RL14) indexed register file: base plus offset
// (RL15) indexed memory: pair plus signed offset
// (RL16) indexed mode limited to load instructions
// (RL17) absolute target loads pc on jump/call
// (RL18) memory loads accept absolute address
// (RL19) vector mode reads pair in low page
// (RL20) vector mode only for call
// (RL21) decode eight explicit operand modes
// (RL22) displacement added to next pc
// (RL23) literal operand taken from instruction field
module oas_operand_address_and_stack (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_REQ_VALID,
  input wire oas_pkg::oas_req_s I_REQ,
  input wire logic [15:0] I_OPND_DATA,
  input wire logic [7:0] I_RP0,
  input wire logic [7:0] I_RP1,
  input wire logic [15:0] I_NEXT_PC,
  output oas_pkg::oas_res_s O_RES,
  output logic O_RES_VALID,
  input wire logic I_STK_START,
  input wire oas_pkg::oas_stk_cmd_e I_STK_CMD,
  input wire logic [15:0] I_PC,
  input wire logic [7:0] I_FLAGS,
  input wire logic [7:0] I_STK_RDATA,
  output logic [7:0] O_STK_ADDR,
  output logic O_STK_WE,
  output logic O_STK_RE,
  output logic [7:0] O_STK_WDATA,
  output logic O_STK_BUSY,
  output logic O_STK_DONE,
  output logic [15:0] O_RET_PC,
  output logic [7:0] O_RET_FLAGS,
  output logic O_SP_WRAP,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WE,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  output logic O_REG_HIT
);

  // ==========================================================
  // helpers
  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction

  function automatic logic in_common(input logic [7:0] a);
    in_common = (a >= oas_pkg::COMMON_BASE) && (a <= oas_pkg::COMMON_TOP);
  endfunction

  function automatic logic in_system(input logic [7:0] a);
    in_system = (a >= oas_pkg::SYSTEM_BASE);
  endfunction

  // ==========================================================
  // operand address generation
  oas_pkg::oas_res_s res_next;
  oas_pkg::oas_res_s res_reg;
  logic res_valid_reg;
  logic [7:0] rp_sel;
  logic [7:0] idx8;

  assign rp_sel = I_REQ.wsel[3] ? I_RP1 : I_RP0;
  assign idx8 = I_REQ.field[7:0] + I_OPND_DATA[7:0];

  always_comb begin
    res_next = '0;
    res_next.space = oas_pkg::space_none;
    // (RL21) eight mode decode
    case (I_REQ.mode)
      oas_pkg::reg_mode: begin
        res_next.space = oas_pkg::space_regfile;
        res_next.ea = {8'h00, I_REQ.field[7:0]};
        // (RL9) register contents operand
        res_next.operand = I_OPND_DATA;
        // (RL3) direct common refused
        // (RL2) pair must be even
        res_next.invalid = in_common(I_REQ.field[7:0]) ||
                           (I_REQ.is_pair && I_REQ.field[0]);
      end
      oas_pkg::work_reg_mode: begin
        res_next.space = oas_pkg::space_regfile;
        // (RL10) slice plus short field
        res_next.ea = {8'h00, rp_sel[7:oas_pkg::SLICE_LSB],
                       I_REQ.wsel[2:0]};
        res_next.operand = I_OPND_DATA;
        res_next.invalid = I_REQ.is_pair && I_REQ.wsel[0];
      end
      oas_pkg::pointer_held_mode: begin
        // (RL11) register holds address
        if (I_REQ.is_pair) begin
          res_next.space = (I_REQ.instr == oas_pkg::external_data_load) ?
                           oas_pkg::space_xdata : oas_pkg::space_pmem;
          res_next.ea = I_OPND_DATA;
        end else begin
          res_next.space = oas_pkg::space_regfile;
          res_next.ea = {8'h00, I_OPND_DATA[7:0]};
          // (RL12) system area unreachable
          res_next.invalid = in_system(I_OPND_DATA[7:0]);
        end
      end
      oas_pkg::indexed_mode: begin
        // (RL16) only load instructions
        case (I_REQ.instr)
          oas_pkg::register_move_instr: begin
            res_next.space = oas_pkg::space_regfile;
            // (RL14) base plus offset
            res_next.ea = {8'h00, idx8};
            // (RL13) system area unreachable
            res_next.invalid = in_system(idx8);
          end
          oas_pkg::program_memory_load,
          oas_pkg::external_data_load: begin
            res_next.space = (I_REQ.instr == oas_pkg::program_memory_load) ?
                             oas_pkg::space_pmem : oas_pkg::space_xdata;
            // (RL15) pair plus signed offset
            res_next.ea = I_OPND_DATA + (I_REQ.long_off ? I_REQ.field :
                          sext8(I_REQ.field[7:0]));
          end
          default: begin
            res_next.invalid = 1'b1;
          end
        endcase
      end
      oas_pkg::absolute_target_mode: begin
        res_next.ea = I_REQ.field;
        case (I_REQ.instr)
          oas_pkg::jump_instr, oas_pkg::call_instr: begin
            // (RL17) load pc directly
            res_next.space = oas_pkg::space_pc;
            res_next.pc_load = 1'b1;
          end
          // (RL18) absolute memory transfer
          oas_pkg::program_memory_load: begin
            res_next.space = oas_pkg::space_pmem;
          end
          oas_pkg::external_data_load: begin
            res_next.space = oas_pkg::space_xdata;
          end
          default: begin
            res_next.invalid = 1'b1;
          end
        endcase
      end
      oas_pkg::vector_table_jump_mode: begin
        // (RL19) pair in lowest page
        res_next.space = oas_pkg::space_pmem;
        res_next.ea = {oas_pkg::VECTOR_PAGE, I_REQ.field[7:0]};
        res_next.vec_fetch = 1'b1;
        // (RL20) call only
        res_next.invalid = (I_REQ.instr != oas_pkg::call_instr);
      end
      oas_pkg::pc_displacement_mode: begin
        // (RL22) next pc plus displacement
        res_next.space = oas_pkg::space_pc;
        res_next.ea = I_NEXT_PC + sext8(I_REQ.field[7:0]);
        res_next.pc_load = 1'b1;
      end
      oas_pkg::literal_operand_mode: begin
        // (RL23) operand from field
        res_next.operand = I_REQ.is_pair ? I_REQ.field :
                           {8'h00, I_REQ.field[7:0]};
      end
      default: begin
        res_next.invalid = 1'b1;
      end
    endcase
    // (RL1) common area ignores page
    res_next.page_bypass = (res_next.space == oas_pkg::space_regfile) &&
                           in_common(res_next.ea[7:0]);
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      res_reg <= '0;
      res_valid_reg <= 1'b0;
    end else begin
      res_reg <= res_next;
      res_valid_reg <= I_REQ_VALID;
    end
  end

  assign O_RES = res_reg;
  assign O_RES_VALID = res_valid_reg;

  // ==========================================================
  // stack sequencer
  oas_pkg::oas_stk_state_e state_reg;
  oas_pkg::oas_stk_state_e state_next;
  logic [7:0] sp_reg;
  logic [15:0] pc_reg;
  logic [7:0] fl_reg;
  logic with_fl_reg;
  logic [15:0] ret_pc_reg;
  logic [7:0] ret_fl_reg;
  logic done_reg;
  logic wrap_reg;
  logic [7:0] rdata_reg;
  logic hit_reg;
  logic idle;
  logic start_ok;
  logic push_step;
  logic pop_step;
  logic sp_write;

  assign idle = (state_reg == oas_pkg::st_idle);
  assign start_ok = I_STK_START && idle;
  assign push_step = (state_reg == oas_pkg::st_push_lo) ||
                     (state_reg == oas_pkg::st_push_hi) ||
                     (state_reg == oas_pkg::st_push_fl);
  assign pop_step = (state_reg == oas_pkg::st_pop_fl) ||
                    (state_reg == oas_pkg::st_pop_hi) ||
                    (state_reg == oas_pkg::st_pop_lo);
  // software write refused while a sequence runs
  assign sp_write = I_REG_WE && idle &&
                    (I_REG_ADDR == oas_pkg::STACK_PTR_ADDR);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      oas_pkg::st_idle: begin
        if (I_STK_START) begin
          case (I_STK_CMD)
            oas_pkg::stk_call, oas_pkg::stk_intr: begin
              state_next = oas_pkg::st_push_lo;
            end
            oas_pkg::stk_return: begin
              state_next = oas_pkg::st_pop_hi;
            end
            default: begin
              state_next = oas_pkg::st_pop_fl;
            end
          endcase
        end
      end
      oas_pkg::st_push_lo: begin
        state_next = oas_pkg::st_push_hi;
      end
      oas_pkg::st_push_hi: begin
        state_next = with_fl_reg ? oas_pkg::st_push_fl : oas_pkg::st_idle;
      end
      oas_pkg::st_pop_fl: begin
        state_next = oas_pkg::st_pop_hi;
      end
      oas_pkg::st_pop_hi: begin
        state_next = oas_pkg::st_pop_lo;
      end
      default: begin
        state_next = oas_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      state_reg <= oas_pkg::st_idle;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      pc_reg <= 16'h0000;
      fl_reg <= 8'h00;
      with_fl_reg <= 1'b0;
    end else if (start_ok) begin
      pc_reg <= I_PC;
      fl_reg <= I_FLAGS;
      with_fl_reg <= (I_STK_CMD == oas_pkg::stk_intr);
    end
  end

  // (RL6) pre-decrement, post-increment
  // (RL8) modulo 256 wrap
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      sp_reg <= oas_pkg::STACK_PTR_RESET;
    end else if (push_step) begin
      sp_reg <= sp_reg - 8'h01;
    end else if (pop_step) begin
      sp_reg <= sp_reg + 8'h01;
    end else if (sp_write) begin
      sp_reg <= I_REG_WDATA;
    end
  end

  assign O_STK_ADDR = push_step ? sp_reg - 8'h01 : sp_reg;
  assign O_STK_WE = push_step;
  assign O_STK_RE = pop_step;

  // (RL4) pc low byte then high byte
  // (RL5) flags pushed last
  always_comb begin
    case (state_reg)
      oas_pkg::st_push_lo: O_STK_WDATA = pc_reg[7:0];
      oas_pkg::st_push_hi: O_STK_WDATA = pc_reg[15:8];
      oas_pkg::st_push_fl: O_STK_WDATA = fl_reg;
      default: O_STK_WDATA = 8'h00;
    endcase
  end

  // (RL5) restore flags and pc
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      ret_pc_reg <= 16'h0000;
      ret_fl_reg <= 8'h00;
    end else begin
      if (state_reg == oas_pkg::st_pop_fl) begin
        ret_fl_reg <= I_STK_RDATA;
      end
      if (state_reg == oas_pkg::st_pop_hi) begin
        ret_pc_reg[15:8] <= I_STK_RDATA;
      end
      if (state_reg == oas_pkg::st_pop_lo) begin
        ret_pc_reg[7:0] <= I_STK_RDATA;
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      done_reg <= 1'b0;
      wrap_reg <= 1'b0;
    end else begin
      done_reg <= (push_step || pop_step) &&
                  (state_next == oas_pkg::st_idle);
      wrap_reg <= push_step && (sp_reg == 8'h00);
    end
  end

  // (RL7) stack pointer byte readback
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      rdata_reg <= 8'h00;
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= (I_REG_ADDR == oas_pkg::STACK_PTR_ADDR);
      rdata_reg <= (I_REG_ADDR == oas_pkg::STACK_PTR_ADDR) ? sp_reg : 8'h00;
    end
  end

  assign O_STK_BUSY = !idle;
  assign O_STK_DONE = done_reg;
  assign O_RET_PC = ret_pc_reg;
  assign O_RET_FLAGS = ret_fl_reg;
  assign O_SP_WRAP = wrap_reg;
  assign O_REG_RDATA = rdata_reg;
  assign O_REG_HIT = hit_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  sequence call_push_s;
    state_reg == oas_pkg::st_push_lo ##1 state_reg == oas_pkg::st_push_hi
      ##1 state_reg == oas_pkg::st_idle;
  endsequence

  sequence intr_push_s;
    state_reg == oas_pkg::st_push_lo ##1 state_reg == oas_pkg::st_push_hi
      ##1 state_reg == oas_pkg::st_push_fl ##1 O_STK_DONE;
  endsequence

  sequence interrupt_return_pop_s;
    state_reg == oas_pkg::st_pop_fl ##1 state_reg == oas_pkg::st_pop_hi
      ##1 state_reg == oas_pkg::st_pop_lo ##1 O_STK_DONE;
  endsequence

  call_order_a: // (RL4)
    assert property (start_ok && I_STK_CMD == oas_pkg::stk_call
      |=> call_push_s) else $error("call push order wrong");
  intr_order_a: // (RL5)
    assert property (start_ok && I_STK_CMD == oas_pkg::stk_intr
      |=> intr_push_s) else $error("interrupt push order wrong");
  interrupt_return_order_a: // (RL5)
    assert property (start_ok && I_STK_CMD == oas_pkg::interrupt_return
      |=> interrupt_return_pop_s) else $error("interrupt return pop order wrong");
  ret_pc_a: // (RL4)
    assert property (state_reg == oas_pkg::st_pop_hi ##1
      state_reg == oas_pkg::st_pop_lo |=> O_RET_PC ==
      {$past(I_STK_RDATA, 2), $past(I_STK_RDATA)})
      else $error("returned pc not popped bytes");
  push_dec_a: // (RL6)
    assert property (O_STK_WE |-> O_STK_ADDR == sp_reg - 8'h01 ##1
      sp_reg == $past(O_STK_ADDR)) else $error("push not pre-decrement");
  pop_inc_a: // (RL6)
    assert property (O_STK_RE |-> O_STK_ADDR == sp_reg ##1
      sp_reg == $past(sp_reg) + 8'h01) else $error("pop not post-increment");
  sp_wrap_a: // (RL8)
    assert property (O_STK_WE && sp_reg == 8'h00 |=> sp_reg == 8'hff &&
      O_SP_WRAP) else $error("stack pointer wrap wrong");
  sp_read_a: // (RL7)
    assert property (I_REG_ADDR == oas_pkg::STACK_PTR_ADDR |=> O_REG_HIT &&
      O_REG_RDATA == $past(sp_reg)) else $error("stack pointer readback");
  common_direct_a: // (RL3)
    assert property (I_REQ_VALID && I_REQ.mode == oas_pkg::reg_mode &&
      I_REQ.field[7:4] == 4'hc |=> O_RES.invalid)
      else $error("direct common address accepted");
  pair_even_a: // (RL2)
    assert property (I_REQ_VALID && I_REQ.mode == oas_pkg::reg_mode &&
      I_REQ.is_pair && I_REQ.field[0] |=> O_RES.invalid)
      else $error("odd register pair accepted");
  work_slice_a: // (RL10)
    assert property (I_REQ_VALID && I_REQ.mode == oas_pkg::work_reg_mode
      |=> O_RES.ea[7:3] == $past(rp_sel[7:3]) &&
      O_RES.ea[2:0] == $past(I_REQ.wsel[2:0]))
      else $error("working register slice wrong");
  common_bypass_a: // (RL1)
    assert property (I_REQ_VALID && I_REQ.mode == oas_pkg::work_reg_mode &&
      rp_sel[7:4] == 4'hc |=> O_RES.page_bypass)
      else $error("common area not page free");
  ptr_system_a: // (RL12)
    assert property (I_REQ_VALID && I_REQ.mode == oas_pkg::pointer_held_mode
      && !I_REQ.is_pair && I_OPND_DATA[7:6] == 2'b11 |=> O_RES.invalid)
      else $error("pointer reached system area");
  idx_sum_a: // (RL14)
    assert property (I_REQ_VALID && I_REQ.mode == oas_pkg::indexed_mode &&
      I_REQ.instr == oas_pkg::register_move_instr |=> O_RES.ea[7:0] ==
      8'($past(I_REQ.field[7:0]) + $past(I_OPND_DATA[7:0])))
      else $error("indexed sum wrong");
  vec_call_a: // (RL20)
    assert property (I_REQ_VALID && I_REQ.mode ==
      oas_pkg::vector_table_jump_mode |=> O_RES.invalid ==
      ($past(I_REQ.instr) != oas_pkg::call_instr))
      else $error("vector mode accepted off call");
  disp_target_a: // (RL22)
    assert property (I_REQ_VALID && I_REQ.mode ==
      oas_pkg::pc_displacement_mode |=> O_RES.ea == $past(I_NEXT_PC) +
      sext8($past(I_REQ.field[7:0])) && O_RES.pc_load)
      else $error("displacement target wrong");

endmodule

// ==== dv/operand_address_and_stack_test.sv ====
`timescale 1ns/1ps

module operand_address_and_stack_test;
  // ==========================================================
  // short names for modes and instruction classes
  localparam oas_pkg::oas_mode_e md_reg = oas_pkg::reg_mode;
  localparam oas_pkg::oas_mode_e md_wrk = oas_pkg::work_reg_mode;
  localparam oas_pkg::oas_mode_e md_ptr = oas_pkg::pointer_held_mode;
  localparam oas_pkg::oas_mode_e md_idx = oas_pkg::indexed_mode;
  localparam oas_pkg::oas_mode_e md_abs = oas_pkg::absolute_target_mode;
  localparam oas_pkg::oas_mode_e md_vec = oas_pkg::vector_table_jump_mode;
  localparam oas_pkg::oas_mode_e md_rel = oas_pkg::pc_displacement_mode;
  localparam oas_pkg::oas_mode_e md_lit = oas_pkg::literal_operand_mode;
  localparam oas_pkg::oas_instr_e in_mov = oas_pkg::register_move_instr;
  localparam oas_pkg::oas_instr_e in_pml = oas_pkg::program_memory_load;
  localparam oas_pkg::oas_instr_e in_xdl = oas_pkg::external_data_load;
  localparam oas_pkg::oas_instr_e in_jmp = oas_pkg::jump_instr;
  localparam oas_pkg::oas_instr_e in_cal = oas_pkg::call_instr;
  localparam oas_pkg::oas_instr_e in_oth = oas_pkg::other_instr;

  // ==========================================================
  // signals, clock and stack memory
  logic I_MCLK = 0;
  logic I_RST = 1;
  logic I_REQ_VALID = 0;
  oas_pkg::oas_req_s I_REQ = '0;
  logic [15:0] I_OPND_DATA = 0;
  logic [7:0] I_RP0 = 8'hc0;
  logic [7:0] I_RP1 = 8'hc8;
  logic [15:0] I_NEXT_PC = 0;
  oas_pkg::oas_res_s O_RES;
  logic O_RES_VALID;
  logic I_STK_START = 0;
  oas_pkg::oas_stk_cmd_e I_STK_CMD = oas_pkg::stk_call;
  logic [15:0] I_PC = 0;
  logic [7:0] I_FLAGS = 0;
  logic [7:0] I_STK_RDATA;
  logic [7:0] O_STK_ADDR, O_STK_WDATA, O_RET_FLAGS, O_REG_RDATA;
  logic O_STK_WE, O_STK_RE, O_STK_BUSY, O_STK_DONE, O_SP_WRAP, O_REG_HIT;
  logic [15:0] O_RET_PC;
  logic [7:0] I_REG_ADDR = 0;
  logic I_REG_WE = 0;
  logic [7:0] I_REG_WDATA = 0;
  logic [7:0] mem [256];
  int fail_count = 0;
  int total_checks = 0;

  always #12.5 I_MCLK = ~I_MCLK;

  // register file behind the stack, combinational read
  always @(posedge I_MCLK) begin
    if (O_STK_WE) mem[O_STK_ADDR] <= O_STK_WDATA;
  end
  assign I_STK_RDATA = mem[O_STK_ADDR];

  oas_operand_address_and_stack dut_u (.I_MCLK(I_MCLK), .I_RST(I_RST),
    .I_REQ_VALID(I_REQ_VALID), .I_REQ(I_REQ), .I_OPND_DATA(I_OPND_DATA),
    .I_RP0(I_RP0), .I_RP1(I_RP1), .I_NEXT_PC(I_NEXT_PC), .O_RES(O_RES),
    .O_RES_VALID(O_RES_VALID), .I_STK_START(I_STK_START),
    .I_STK_CMD(I_STK_CMD), .I_PC(I_PC), .I_FLAGS(I_FLAGS),
    .I_STK_RDATA(I_STK_RDATA), .O_STK_ADDR(O_STK_ADDR),
    .O_STK_WE(O_STK_WE), .O_STK_RE(O_STK_RE), .O_STK_WDATA(O_STK_WDATA),
    .O_STK_BUSY(O_STK_BUSY), .O_STK_DONE(O_STK_DONE), .O_RET_PC(O_RET_PC),
    .O_RET_FLAGS(O_RET_FLAGS), .O_SP_WRAP(O_SP_WRAP),
    .I_REG_ADDR(I_REG_ADDR), .I_REG_WE(I_REG_WE),
    .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
    .O_REG_HIT(O_REG_HIT));

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // k: 0 valid with address check, 1 refused, 2 valid without address
  task automatic req(input oas_pkg::oas_mode_e m, input oas_pkg::oas_instr_e n,
      input logic p, input logic lo, input logic [3:0] ws,
      input logic [15:0] f, input logic [15:0] od, input logic [1:0] k,
      input logic [15:0] ea);
    @(posedge I_MCLK);
    #1;
    chk(O_RES_VALID, 1'b0);
    I_REQ = {m, n, p, lo, ws, f};
    I_OPND_DATA = od;
    I_REQ_VALID = 1;
    @(posedge I_MCLK);
    #1;
    I_REQ_VALID = 0;
    chk(O_RES_VALID, 1'b1);
    chk(O_RES.invalid, k == 2'h1);
    if (k == 2'h0) chk(O_RES.ea, ea);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    I_REG_ADDR = a;
    @(posedge I_MCLK);
    #1;
    d = O_REG_RDATA;
    chk(O_REG_HIT, a == oas_pkg::STACK_PTR_ADDR);
  endtask

  task automatic wr_sp(input logic [7:0] d);
    I_REG_ADDR = oas_pkg::STACK_PTR_ADDR;
    I_REG_WDATA = d;
    I_REG_WE = 1;
    @(posedge I_MCLK);
    #1;
    I_REG_WE = 0;
  endtask

  // start is held over a second edge, which must be ignored while busy
  task automatic stk(input oas_pkg::oas_stk_cmd_e c, input logic [15:0] pc,
      input logic [7:0] fl, input logic [7:0] sp0, input logic ew);
    logic push;
    int n;
    logic w;
    logic [7:0] d;
    logic [7:0] pv [3];
    push = (c == oas_pkg::stk_call) || (c == oas_pkg::stk_intr);
    n = (c == oas_pkg::stk_call || c == oas_pkg::stk_return) ? 2 : 3;
    pv = '{pc[7:0], pc[15:8], fl};
    w = 0;
    I_STK_CMD = c;
    I_PC = pc;
    I_FLAGS = fl;
    I_STK_START = 1;
    @(posedge I_MCLK);
    #1;
    for (int i = 0; i < n; i++) begin
      chk(O_STK_ADDR, push ? 8'(sp0 - i - 1) : 8'(sp0 + i));
      chk(O_STK_BUSY, 1'b1);
      chk(O_STK_WE, push);
      chk(O_STK_RE, !push);
      if (push) chk(O_STK_WDATA, pv[i]);
      w |= O_SP_WRAP;
      @(posedge I_MCLK);
      #1;
      I_STK_START = 0;
    end
    chk(O_STK_DONE, 1'b1);
    chk(O_STK_BUSY, 1'b0);
    w |= O_SP_WRAP;
    chk(w, ew);
    if (!push) chk(O_RET_PC, pc);
    if (!push && n == 3) chk(O_RET_FLAGS, fl);
    rd(oas_pkg::STACK_PTR_ADDR, d);
    chk(d, push ? 8'(sp0 - n) : 8'(sp0 + n));
  endtask

  // ==========================================================
  // scenarios
  task automatic t_register;
    req(md_reg, in_mov, 1, 0, 4'h0, 16'h0042, 16'hbeef, 0, 16'h0042);
    chk(O_RES.operand, 16'hbeef);
    chk(O_RES.space, oas_pkg::space_regfile);
    req(md_reg, in_mov, 0, 0, 4'h0, 16'h00c2, 16'h0000, 1, 16'h0);
    req(md_reg, in_mov, 1, 0, 4'h0, 16'h0043, 16'h0000, 1, 16'h0);
  endtask

  task automatic t_working;
    req(md_wrk, in_mov, 0, 0, 4'h2, 16'h0000, 16'h0000, 0, 16'h00c2);
    chk(O_RES.page_bypass, 1'b1);
    I_RP1 = 8'h48;
    req(md_wrk, in_mov, 0, 0, 4'hb, 16'h0000, 16'h0000, 0, 16'h004b);
    chk(O_RES.page_bypass, 1'b0);
  endtask

  task automatic t_pointer;
    req(md_ptr, in_mov, 0, 0, 4'h0, 16'h0000, 16'h0055, 0, 16'h0055);
    req(md_ptr, in_mov, 0, 0, 4'h0, 16'h0000, 16'h00c5, 1, 16'h0);
    req(md_ptr, in_pml, 1, 0, 4'h0, 16'h0000, 16'h1234, 0, 16'h1234);
    chk(O_RES.space, oas_pkg::space_pmem);
    req(md_ptr, in_xdl, 1, 0, 4'h0, 16'h0000, 16'h4321, 0, 16'h4321);
    chk(O_RES.space, oas_pkg::space_xdata);
  endtask

  task automatic t_indexed;
    req(md_idx, in_mov, 0, 0, 4'h0, 16'h0010, 16'h0020, 0, 16'h0030);
    req(md_idx, in_mov, 0, 0, 4'h0, 16'h00b0, 16'h0020, 1, 16'h0);
    req(md_idx, in_jmp, 0, 0, 4'h0, 16'h0010, 16'h0020, 1, 16'h0);
    req(md_idx, in_pml, 1, 0, 4'h0, 16'h00f0, 16'h1000, 0, 16'h0ff0);
    req(md_idx, in_pml, 1, 0, 4'h0, 16'h007f, 16'h1000, 0, 16'h107f);
    req(md_idx, in_xdl, 1, 1, 4'h0, 16'h0123, 16'h1000, 0, 16'h1123);
  endtask

  task automatic t_absolute;
    req(md_abs, in_jmp, 0, 0, 4'h0, 16'h2345, 16'h0000, 0, 16'h2345);
    chk(O_RES.pc_load, 1'b1);
    req(md_abs, in_cal, 0, 0, 4'h0, 16'h3456, 16'h0000, 0, 16'h3456);
    chk(O_RES.pc_load, 1'b1);
    req(md_abs, in_pml, 0, 0, 4'h0, 16'h0abc, 16'h0000, 0, 16'h0abc);
    chk(O_RES.pc_load, 1'b0);
    req(md_abs, in_xdl, 0, 0, 4'h0, 16'h1abc, 16'h0000, 0, 16'h1abc);
    req(md_abs, in_oth, 0, 0, 4'h0, 16'h1abc, 16'h0000, 1, 16'h0);
  endtask

  task automatic t_vector;
    req(md_vec, in_cal, 0, 0, 4'h0, 16'hff34, 16'h0000, 0, 16'h0034);
    chk(O_RES.vec_fetch, 1'b1);
    req(md_vec, in_jmp, 0, 0, 4'h0, 16'h0034, 16'h0000, 1, 16'h0);
  endtask

  task automatic t_rel_lit;
    I_NEXT_PC = 16'h0100;
    req(md_rel, in_jmp, 0, 0, 4'h0, 16'h0080, 16'h0000, 0, 16'h0080);
    req(md_rel, in_jmp, 0, 0, 4'h0, 16'h007f, 16'h0000, 0, 16'h017f);
    req(md_lit, in_mov, 1, 0, 4'h0, 16'hbeef, 16'h0000, 2, 16'h0);
    chk(O_RES.operand, 16'hbeef);
    req(md_lit, in_mov, 0, 0, 4'h0, 16'h12ab, 16'h0000, 2, 16'h0);
    chk(O_RES.operand, 16'h00ab);
  endtask

  task automatic t_regbus;
    logic [7:0] d;
    rd(oas_pkg::STACK_PTR_ADDR, d);
    chk(d, oas_pkg::STACK_PTR_RESET);
    rd(8'h40, d);
    chk(d, 8'h00);
  endtask

  task automatic t_stack;
    stk(oas_pkg::stk_call, 16'h1234, 8'h00, 8'hc0, 0);
    stk(oas_pkg::stk_intr, 16'hbeef, 8'ha5, 8'hbe, 0);
    stk(oas_pkg::interrupt_return, 16'hbeef, 8'ha5, 8'hbb, 0);
    stk(oas_pkg::stk_return, 16'h1234, 8'h00, 8'hbe, 0);
    wr_sp(8'h01);
    stk(oas_pkg::stk_call, 16'ha55a, 8'h00, 8'h01, 1);
    stk(oas_pkg::stk_return, 16'ha55a, 8'h00, 8'hff, 0);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (6) @(posedge I_MCLK);
    #1;
    I_RST = 0;
    t_regbus();
    t_register();
    t_working();
    t_pointer();
    t_indexed();
    t_absolute();
    t_vector();
    t_rel_lit();
    t_stack();
    summarize();
  end

  initial begin
    #100000;
    fail_count++;
    summarize();
  end
endmodule
